// *** rtl/dsk_map.svh ***
// Purpose: Register offsets, field positions and reset values of the keying and sweep controller
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word
// Notes:   Definitions only
`ifndef DSK_MAP_SVH
`define DSK_MAP_SVH

// Register byte addresses
`define DSK_A_CFR   8'h00
`define DSK_A_AMP   8'h04
`define DSK_A_RATE  8'h08
`define DSK_A_TUNE  8'h0c
`define DSK_A_PHASE 8'h10
`define DSK_A_SEG   8'h20
`define DSK_A_END   8'h40
`define DSK_A_RAMA  8'h40
`define DSK_A_RAMD  8'h44
`define DSK_A_STAT  8'h48

// Word indexes of the buffered registers
`define DSK_I_CFR   4'h0
`define DSK_I_AMP   4'h1
`define DSK_I_RATE  4'h2
`define DSK_I_TUNE  4'h3
`define DSK_I_PHASE 4'h4

// First control register bits
`define DSK_B_RAMEN  31
`define DSK_B_DEST   30
`define DSK_B_RELOAD 26
`define DSK_B_KEYEN  25
`define DSK_B_AUTO   24
`define DSK_B_NODW   2

// Values
`define DSK_FULL     14'h3fff
`define DSK_REG_RST  32'h0000_0000
`define DSK_OKAY     2'b00
`define DSK_SLVERR   2'b10

`endif

// *** rtl/dsk_pkg.sv ***
// Purpose: Types shared by the keying and sweep controller
// Assumes: Nothing beyond the map header
// Notes:   Enums carry no explicit codes
package dsk_pkg;

  // Sweep behaviour of the current segment
  typedef enum logic [2:0] {
    DSK_DIRECT,
    DSK_RAMP_UP,
    DSK_BIDIR,
    DSK_CONT_BIDIR,
    DSK_RECIRC
  } dsk_mode_t;

  // Source of the amplitude scale factor
  typedef enum logic [1:0] {
    DSK_SC_OFF,
    DSK_SC_MANUAL,
    DSK_SC_AUTO
  } dsk_scale_t;

endpackage : dsk_pkg

// *** rtl/dsk_ctrl.sv ***
// Purpose: Shaped keying scale generator and RAM sweep address controller behind AXI4-Lite
// Assumes: Pins are asynchronous to aclk; registers become active on a rising update pin
// Notes:   Outputs feed a data path multiplier, the phase accumulator and the offset adder
`include "dsk_map.svh"

// Overview of operation
// RULE1: Auto keying: 14-bit counter paced by rate
// RULE2: Keying pin high counts up, low down
// RULE3: Scale factor unsigned, 0x3fff is full scale
// RULE4: Step field selects step 1,2,4,8
// RULE5: Auto scale never exceeds amplitude register
// RULE6: Timer counts down, reloads at one
// RULE7: Reload bit: reload on update, profile change
// RULE8: Pin toggle, update, profile change reload early
// RULE9: Enabling auto keying reloads the timer
// RULE10: Manual keying applies amplitude register directly
// RULE11: Single tone uses tuning register after update
// RULE12: Host keeps segment begin below final
// RULE13: Profile change or update restarts sweep; code skips the profile-change restart in bidirectional mode
// RULE14: Destination bit routes RAM to frequency/phase
// RULE15: Decode segment mode, invalid means direct
// RULE16: No-dwell bit only matters in ramp up
// RULE17: RAM enable bit plus segment mode enable sweeps
// RULE18: Direct switch outputs beginning address word
// RULE19: Profile pins select the keyed RAM word
// RULE20: Phase destination ignores RAM bits 17:0
// RULE21: Ramp up steps address until final address
// RULE22: Bidirectional uses profile 0, low pin direction
// RULE23: Bidirectional steps by pin, stalls at ends
// RULE24: Bit 25 enables keying, bit 24 picks auto
// RULE25: Scale counter saturates, never wraps
module dsk_ctrl #(
  parameter int AW = 10,                    // RAM address bits
  parameter int RW = 16                     // Segment ramp rate bits
) (
  input  wire logic        aclk,            // System clock
  input  wire logic        aresetn,         // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output wire logic        s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte enables
  input  wire logic        s_axi_wvalid,    // Write data valid
  output wire logic        s_axi_wready,    // Write data ready
  output wire logic [1:0]  s_axi_bresp,     // Write response
  output wire logic        s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [7:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output wire logic        s_axi_arready,   // Read address ready
  output wire logic [31:0] s_axi_rdata,     // Read data
  output wire logic [1:0]  s_axi_rresp,     // Read response
  output wire logic        s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        keying_ramp_pin, // Keying direction pin
  input  wire logic        profile_select_low,  // Profile pin 0
  input  wire logic        profile_select_high, // Profile pin 1
  input  wire logic        io_update,       // Register update strobe pin
  output wire logic [13:0] scale_factor,    // Amplitude multiplier input
  output wire logic [31:0] frequency_tuning_word, // Phase accumulator step
  output wire logic [13:0] phase_offset_word      // Phase offset adder input
);

  localparam int NW = 16;

  // Buffered and active register banks, sweep RAM
  logic [31:0] buf_ff [NW];
  logic [31:0] act_ff [NW];
  logic [31:0] mem [1 << AW];

  logic [3:0]  sync1_ff, sync2_ff, prev_ff;
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic        aw_got_ff, w_got_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [7:0]  awa_ff;
  logic [31:0] wd_ff, rdata_ff, rd_val;
  logic [3:0]  ws_ff;
  logic [AW-1:0] ram_wa_ff, addr_ff, nxt_addr;
  logic [31:0] ram_q_ff, tune_ff;
  logic [13:0] phase_ff, scale_ff, cnt_ff, nxt_cnt;
  logic [7:0]  tmr_ff;
  logic [RW-1:0] rt_ff, nxt_rt;
  logic        dir_ff, nxt_dir, done_ff, nxt_done, auto_pv_ff, upd_go_ff;

  // Word index of a byte address
  function automatic logic [3:0] widx(input logic [7:0] a);
    return a[5:2];
  endfunction : widx

  // Address decode shared by both channels
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && ((a < 8'h14) || ((a >= `DSK_A_SEG) && (a < `DSK_A_END)) ||
           (a == `DSK_A_RAMA) || (a == `DSK_A_RAMD) || (a == `DSK_A_STAT));
  endfunction : mapped

  // Byte enable merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Segment mode decode, unknown codes fall back to direct switch
  function automatic dsk_pkg::dsk_mode_t decode(input logic [2:0] c);
    case (c)
      3'h1:    return dsk_pkg::DSK_RAMP_UP;
      3'h2:    return dsk_pkg::DSK_BIDIR;
      3'h3:    return dsk_pkg::DSK_CONT_BIDIR;
      3'h4:    return dsk_pkg::DSK_RECIRC;
      default: return dsk_pkg::DSK_DIRECT; // RULE15
    endcase
  endfunction : decode

  // Two-stage synchronisers, third stage for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff  <= 4'h0;
    end else begin
      sync1_ff <= {io_update, profile_select_high, profile_select_low, keying_ramp_pin};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  logic       key_s, low_s, upd_rise, prof_chg, key_tgl, low_chg;
  logic [1:0] prof;
  assign key_s    = sync2_ff[0];
  assign low_s    = sync2_ff[1];
  assign prof     = sync2_ff[2:1];
  assign upd_rise = sync2_ff[3] & ~prev_ff[3];
  assign prof_chg = sync2_ff[2:1] != prev_ff[2:1];
  assign key_tgl  = sync2_ff[0] ^ prev_ff[0];
  assign low_chg  = sync2_ff[1] ^ prev_ff[1];

  // Write channel handshakes
  logic aw_hs, w_hs, wr_do, nxt_aw_got, nxt_w_got, nxt_bvalid;
  assign aw_hs      = s_axi_awvalid & awready_ff;
  assign w_hs       = s_axi_wvalid & wready_ff;
  assign wr_do      = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign nxt_aw_got = aw_got_ff ? ~wr_do : aw_hs;
  assign nxt_w_got  = w_got_ff ? ~wr_do : w_hs;
  assign nxt_bvalid = wr_do | (bvalid_ff & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DSK_OKAY;
      awa_ff     <= 8'h00;
      wd_ff      <= 32'h0000_0000;
      ws_ff      <= 4'h0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awready_ff <= ~nxt_aw_got;
      wready_ff  <= ~nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
      if (aw_hs) begin
        awa_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (wr_do) begin
        bresp_ff <= mapped(awa_ff) ? `DSK_OKAY : `DSK_SLVERR;
      end
    end
  end

  // Buffer bank writes and transfer to the active bank on update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NW; i++) begin
        buf_ff[i] <= `DSK_REG_RST;
        act_ff[i] <= `DSK_REG_RST;
      end
      upd_go_ff <= 1'b0;
    end else begin
      if (wr_do && mapped(awa_ff) && (awa_ff < `DSK_A_END)) begin
        buf_ff[widx(awa_ff)] <= merge(buf_ff[widx(awa_ff)], wd_ff, ws_ff);
      end
      upd_go_ff <= upd_rise; // Consumers start once the active bank holds the new words
      if (upd_rise) begin
        for (int i = 0; i < NW; i++) begin
          act_ff[i] <= buf_ff[i]; // RULE11
        end
      end
    end
  end

  // RAM loading through an auto-incrementing address port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_wa_ff <= '0;
    end else if (wr_do && (awa_ff == `DSK_A_RAMA)) begin
      ram_wa_ff <= wd_ff[AW-1:0];
    end else if (wr_do && (awa_ff == `DSK_A_RAMD)) begin
      ram_wa_ff <= ram_wa_ff + 1'b1;
    end
  end

  // RAM array, write and registered read
  always_ff @(posedge aclk) begin
    if (wr_do && (awa_ff == `DSK_A_RAMD)) begin
      mem[ram_wa_ff] <= merge(mem[ram_wa_ff], wd_ff, ws_ff);
    end
    ram_q_ff <= mem[addr_ff];
  end

  // Read data selection
  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr < `DSK_A_END) begin
      rd_val = buf_ff[widx(s_axi_araddr)];
    end else if (s_axi_araddr == `DSK_A_RAMA) begin
      rd_val = 32'(ram_wa_ff);
    end else if (s_axi_araddr == `DSK_A_STAT) begin
      rd_val = {{(16 - AW){1'b0}}, addr_ff, 2'b00, cnt_ff};
    end
    if (!mapped(s_axi_araddr)) begin
      rd_val = 32'h0000_0000;
    end
  end

  // Read channel
  logic ar_hs, nxt_rvalid;
  assign ar_hs      = s_axi_arvalid & arready_ff;
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `DSK_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_val;
        rresp_ff <= mapped(s_axi_araddr) ? `DSK_OKAY : `DSK_SLVERR;
      end
    end
  end

  // Active control fields
  logic [31:0] cfr, amp;
  logic [7:0]  rate;
  logic [13:0] lim;
  logic [14:0] step;
  logic        ram_on, to_phase, ramp_reload_on_update, no_dwell;
  dsk_pkg::dsk_scale_t sc_mode;
  assign cfr      = act_ff[`DSK_I_CFR];
  assign amp      = act_ff[`DSK_I_AMP];
  assign rate     = act_ff[`DSK_I_RATE][7:0];
  assign lim      = amp[13:0];
  assign step     = 15'h0001 << amp[15:14]; // RULE4
  assign ram_on   = cfr[`DSK_B_RAMEN];     // RULE17
  assign to_phase = cfr[`DSK_B_DEST];
  assign ramp_reload_on_update = cfr[`DSK_B_RELOAD];
  assign no_dwell = cfr[`DSK_B_NODW];
  assign sc_mode  = !cfr[`DSK_B_KEYEN] ? dsk_pkg::DSK_SC_OFF :
                    cfr[`DSK_B_AUTO] ? dsk_pkg::DSK_SC_AUTO : dsk_pkg::DSK_SC_MANUAL; // RULE24

  // Keying ramp timer control; update reloads use the freshly transferred rate
  logic sc_auto, en_rise, key_load, tick;
  assign sc_auto  = sc_mode == dsk_pkg::DSK_SC_AUTO;
  assign en_rise  = sc_auto & ~auto_pv_ff;                                 // RULE9
  assign key_load = key_tgl | upd_go_ff | prof_chg | en_rise |             // RULE8
                    (ramp_reload_on_update & (upd_go_ff | prof_chg));      // RULE7
  assign tick     = sc_auto & (tmr_ff <= 8'h01) & ~key_load;

  // Ramp rate down counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_ff     <= 8'h00;
      auto_pv_ff <= 1'b0;
    end else begin
      auto_pv_ff <= sc_auto;
      if (key_load || tick || !sc_auto) begin
        tmr_ff <= rate;            // RULE6
      end else begin
        tmr_ff <= tmr_ff - 8'h01;  // RULE6
      end
    end
  end

  // Saturating scale counter, clamped to the amplitude register
  logic [14:0] up_sum;
  always_comb begin
    up_sum  = {1'b0, cnt_ff} + step;
    nxt_cnt = cnt_ff;
    if (tick) begin
      if (key_s) begin                                          // RULE2
        nxt_cnt = (up_sum > {1'b0, lim}) ? lim : up_sum[13:0]; // RULE25
      end else begin
        nxt_cnt = ({1'b0, cnt_ff} < step) ? 14'h0000 : cnt_ff - step[13:0]; // RULE25
      end
    end
    if (sc_auto && (nxt_cnt > lim)) begin
      nxt_cnt = lim; // RULE5
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 14'h0000;
    end else begin
      cnt_ff <= nxt_cnt; // RULE1
    end
  end

  // Scale factor source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scale_ff <= `DSK_FULL;
    end else begin
      case (sc_mode)
        dsk_pkg::DSK_SC_AUTO:   scale_ff <= cnt_ff; // RULE1
        dsk_pkg::DSK_SC_MANUAL: scale_ff <= lim;    // RULE10
        default:                scale_ff <= `DSK_FULL; // RULE3
      endcase
    end
  end

  // Segment selection; bidirectional ramp always works from profile 0
  dsk_pkg::dsk_mode_t cur_mode;
  logic [1:0]    sp;
  logic [31:0]   seg_a, seg_b;
  logic [RW-1:0] seg_rate;
  logic [AW-1:0] seg_beg, seg_fin;
  logic          start, expire;
  assign cur_mode = decode(act_ff[{1'b1, prof, 1'b0}][7:5]);
  assign sp       = (cur_mode == dsk_pkg::DSK_BIDIR) ? 2'b00 : prof; // RULE22
  assign seg_a    = act_ff[{1'b1, sp, 1'b0}];
  assign seg_b    = act_ff[{1'b1, sp, 1'b1}];
  assign seg_rate = seg_a[8 +: RW];
  assign seg_beg  = seg_b[AW-1:0]; // RULE19
  assign seg_fin  = seg_b[16 +: AW];
  assign start    = upd_go_ff | (prof_chg & (cur_mode != dsk_pkg::DSK_BIDIR)); // RULE13
  assign expire   = rt_ff <= RW'(1);

  // Sweep address generator
  always_comb begin
    nxt_addr = addr_ff;
    nxt_dir  = dir_ff;
    nxt_done = done_ff;
    nxt_rt   = expire ? seg_rate : rt_ff - 1'b1;
    if (!ram_on) begin
      nxt_rt = seg_rate;
    end else if (start) begin
      nxt_addr = seg_beg; // RULE21
      nxt_rt   = seg_rate;
      nxt_dir  = 1'b1;
      nxt_done = 1'b0;
    end else begin
      case (cur_mode)
        dsk_pkg::DSK_RAMP_UP: begin
          if (expire && !done_ff) begin
            if (addr_ff != seg_fin) begin
              nxt_addr = addr_ff + 1'b1; // RULE21
            end else if (no_dwell) begin
              nxt_addr = seg_beg; // RULE16
              nxt_done = 1'b1;
            end
          end
        end
        dsk_pkg::DSK_BIDIR: begin
          if (low_chg) begin
            nxt_rt = seg_rate;
          end else if (expire && low_s && (addr_ff != seg_fin)) begin
            nxt_addr = addr_ff + 1'b1; // RULE23
          end else if (expire && !low_s && (addr_ff != seg_beg)) begin
            nxt_addr = addr_ff - 1'b1; // RULE23
          end
        end
        dsk_pkg::DSK_CONT_BIDIR: begin
          if (expire) begin
            if (dir_ff && (addr_ff == seg_fin)) begin
              nxt_dir  = 1'b0;
              nxt_addr = addr_ff - 1'b1;
            end else if (!dir_ff && (addr_ff == seg_beg)) begin
              nxt_dir  = 1'b1;
              nxt_addr = addr_ff + 1'b1;
            end else begin
              nxt_addr = dir_ff ? addr_ff + 1'b1 : addr_ff - 1'b1;
            end
          end
        end
        dsk_pkg::DSK_RECIRC: begin
          if (expire) begin
            nxt_addr = (addr_ff == seg_fin) ? seg_beg : addr_ff + 1'b1;
          end
        end
        default: begin
          nxt_addr = seg_beg; // RULE18
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_ff <= '0;
      rt_ff   <= '0;
      dir_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      rt_ff   <= nxt_rt;
      dir_ff  <= nxt_dir;
      done_ff <= nxt_done;
    end
  end

  // Frequency and phase routing of the RAM word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tune_ff  <= 32'h0000_0000;
      phase_ff <= 14'h0000;
    end else begin
      tune_ff  <= (ram_on && !to_phase) ? ram_q_ff : act_ff[`DSK_I_TUNE]; // RULE14
      phase_ff <= (ram_on && to_phase) ? ram_q_ff[31:18] : act_ff[`DSK_I_PHASE][13:0]; // RULE20
    end
  end

  // Port drive from flops
  assign s_axi_awready         = awready_ff;
  assign s_axi_wready          = wready_ff;
  assign s_axi_bvalid          = bvalid_ff;
  assign s_axi_bresp           = bresp_ff;
  assign s_axi_arready         = arready_ff;
  assign s_axi_rvalid          = rvalid_ff;
  assign s_axi_rdata           = rdata_ff;
  assign s_axi_rresp           = rresp_ff;
  assign scale_factor          = scale_ff;
  assign frequency_tuning_word = tune_ff;
  assign phase_offset_word     = phase_ff;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cnt_limit: assert property ($stable(lim) && $past(sc_auto) && sc_auto |-> cnt_ff <= lim) // RULE5
    else $error("scale counter above amplitude limit");
  a_step_up: assert property (tick && key_s && ({1'b0, cnt_ff} + step <= {1'b0, lim}) && $stable(lim)
    |=> cnt_ff == $past(cnt_ff) + $past(step[13:0])) // RULE2
    else $error("scale counter did not step up");
  a_step_down: assert property (tick && !key_s && ({1'b0, cnt_ff} >= step)
    |=> cnt_ff == $past(cnt_ff) - $past(step[13:0]) || !sc_auto) // RULE2
    else $error("scale counter did not step down");
  a_timer_reload: assert property ((tick || (key_load && sc_auto)) |=> tmr_ff == $past(rate)) // RULE6
    else $error("ramp timer not reloaded");
  a_manual_scale: assert property (sc_mode == dsk_pkg::DSK_SC_MANUAL |=> scale_ff == $past(lim)) // RULE10
    else $error("manual scale not applied");
  a_direct_addr: assert property (ram_on && !start && cur_mode == dsk_pkg::DSK_DIRECT
    |=> addr_ff == $past(seg_beg) ##2 1) // RULE18
    else $error("direct switch address wrong");
  a_ramp_stall: assert property (ram_on && !start && cur_mode == dsk_pkg::DSK_RAMP_UP && !no_dwell
    && addr_ff == seg_fin |=> $stable(addr_ff)) // RULE21
    else $error("ramp up moved past final address");
  a_phase_route: assert property (ram_on && to_phase |=> phase_ff == $past(ram_q_ff[31:18])) // RULE20
    else $error("phase word not taken from RAM");
  a_single_tone: assert property (!ram_on |=> tune_ff == $past(act_ff[`DSK_I_TUNE])) // RULE11
    else $error("single tone word wrong");
  a_bvalid_hold: assert property (bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped");

  c_auto_full: cover property (sc_auto && cnt_ff == lim && lim != 14'h0000);
  c_ramp_end: cover property (ram_on && cur_mode == dsk_pkg::DSK_RAMP_UP && addr_ff == seg_fin);
  c_bidir_down: cover property (ram_on && cur_mode == dsk_pkg::DSK_BIDIR && expire && !low_s);
  c_axi_write: cover property (wr_do && mapped(awa_ff));

endmodule : dsk_ctrl

// *** dv/dsk_host.sv ***
// Purpose: Host model that drives the keying, profile and update pins
// Assumes: Every pin changes just after a rising aclk edge
// Notes:   HOLD sets the update pulse length, so a slow host can be mimicked
module dsk_host #(
  parameter int HOLD = 4               // Cycles each update level is held
) (
  input  wire logic aclk,              // System clock
  output logic      keying_ramp_pin,   // Ramp direction
  output logic      profile_select_low,  // Profile pin 0
  output logic      profile_select_high, // Profile pin 1
  output logic      io_update          // Register update strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet pins from time zero
  initial begin
    keying_ramp_pin = 1'b0;
    profile_select_low = 1'b0;
    profile_select_high = 1'b0;
    io_update = 1'b0;
  end

  // Direction of the scale ramp
  task automatic set_key(input logic v);
    @(posedge aclk);
    keying_ramp_pin <= v;
  endtask : set_key

  // Profile pins carry the 4-tone data
  task automatic set_prof(input logic [1:0] p);
    @(posedge aclk);
    profile_select_high <= p[1];
    profile_select_low <= p[0];
  endtask : set_prof

  // One rising edge on the update pin, then back low
  task automatic pulse_update();
    @(posedge aclk);
    io_update <= 1'b1;
    repeat (HOLD) @(posedge aclk);
    io_update <= 1'b0;
    repeat (HOLD) @(posedge aclk);
  endtask : pulse_update
endmodule : dsk_host

// *** dv/dsk_ctrl_bench.sv ***
// Purpose: Self-checking bench of the keying and sweep controller
// Assumes: Host pin model dsk_host; offsets from dsk_map.svh
// Notes:   Tests are sequences of bus and pin calls with expected values
`include "dsk_map.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module dsk_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, key, psl, psh, upd;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d, tune;
  logic [31:0] w [4];
  logic [1:0]  bresp, rresp, rsp;
  logic [13:0] sf, phase;
  int          fail_count, comparisons, cycles;

  dsk_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .keying_ramp_pin(key),
    .profile_select_low(psl), .profile_select_high(psh), .io_update(upd), .scale_factor(sf),
    .frequency_tuning_word(tune), .phase_offset_word(phase));

  dsk_host host (.aclk(aclk), .keying_ramp_pin(key), .profile_select_low(psl),
    .profile_select_high(psh), .io_update(upd));

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      test_done();
    end
  end

  // Bus write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk); // Back-to-back calls never drive bready twice in one step
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Bus read; data and response taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a);
    @(posedge aclk); // Back-to-back calls never drive rready twice in one step
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic upd8();
    host.pulse_update();
    repeat (8) @(posedge aclk);
  endtask : upd8

  initial begin
    int n;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    for (int p = 0; p < 4; p++) w[p] = 32'ha000_0000 + p * 32'h0504_0021;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Bus map and single tone
    `CHK(sf, `DSK_FULL)
    wr(8'h14, 32'h1);
    `CHK(rsp, `DSK_SLVERR)
    rd(8'h14);
    `CHK({rsp, rd_d}, {`DSK_SLVERR, 32'h0})
    wr(`DSK_A_TUNE, 32'h1234_5678);
    rd(`DSK_A_TUNE);
    `CHK({rsp, rd_d}, {`DSK_OKAY, 32'h1234_5678})
    `CHK(tune, 32'h0)
    upd8();
    `CHK(tune, 32'h1234_5678)
    $display("test single tone done");
    // Manual keying
    wr(`DSK_A_AMP, 32'h0000_1234);
    wr(`DSK_A_CFR, 32'h0200_0000);
    upd8();
    `CHK(sf, 14'h1234)
    $display("test manual keying done");
    // Auto keying, every step code, both saturation ends
    wr(`DSK_A_RATE, 32'h2);
    wr(`DSK_A_CFR, 32'h0300_0000);
    for (int c = 0; c < 4; c++) begin
      wr(`DSK_A_AMP, {16'h0, c[1:0], 14'h0018});
      upd8();
      host.set_key(1'b0);
      repeat (60) @(posedge aclk);
      `CHK(sf, 14'h0)
      host.set_key(1'b1);
      n = 0;
      while (sf === 14'h0 && n < 50) begin
        @(posedge aclk);
        n++;
      end
      `CHK(sf, 14'h1 << c)
      repeat (60) @(posedge aclk);
      `CHK(sf, 14'h0018)
    end
    $display("test auto keying done");
    // Direct switch keyed by the profile pins
    wr(`DSK_A_RAMA, 32'h0);
    for (int p = 0; p < 4; p++) wr(`DSK_A_RAMD, w[p]);
    for (int p = 0; p < 4; p++) begin
      wr(8'h20 + 8'(8 * p), 32'h0);
      wr(8'h24 + 8'(8 * p), {6'h0, 10'(p + 4), 6'h0, 10'(p)});
    end
    wr(`DSK_A_CFR, 32'h8000_0000);
    upd8();
    for (int p = 0; p < 4; p++) begin
      host.set_prof(2'(p));
      repeat (8) @(posedge aclk);
      `CHK(tune, w[p])
    end
    wr(`DSK_A_CFR, 32'hc000_0000);
    upd8();
    `CHK(phase, w[3][31:18])
    `CHK(tune, 32'h1234_5678)
    $display("test direct switch done");
    // Ramp up to the final address, then restart
    host.set_prof(2'h0);
    wr(8'h20, 32'h0000_1420);
    wr(8'h24, 32'h0003_0000);
    wr(`DSK_A_CFR, 32'h8000_0000);
    upd8();
    repeat (100) @(posedge aclk);
    rd(`DSK_A_STAT);
    `CHK(rd_d[25:16], 10'h3)
    `CHK(tune, w[3])
    upd8();
    rd(`DSK_A_STAT);
    `CHK(rd_d[25:16], 10'h0)
    // Reserved mode code behaves as direct switch
    wr(8'h20, 32'h0000_00a0);
    wr(8'h24, 32'h0005_0002);
    upd8();
    `CHK(tune, w[2])
    $display("test ramp up done");
    // Bidirectional ramp: profile 0 segment 1..3, profile 1 only selects the mode
    wr(8'h20, 32'h0000_0a40);
    wr(8'h24, 32'h0003_0001);
    wr(8'h28, 32'h0000_0040);
    host.set_prof(2'h1);
    upd8();
    repeat (60) @(posedge aclk);
    `CHK(tune, w[3])
    host.set_prof(2'h0);
    repeat (60) @(posedge aclk);
    `CHK(tune, w[1])
    $display("test bidirectional ramp done");
    test_done();
  end
endmodule : dsk_ctrl_bench
